// ### hw/fbod_host.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Reads drive chip-select and output-gate low, write strobe high.
// - Commands drive chip-select and write strobe low, output-gate high.
// - Bypass mode programs with two write cycles instead of four.
// - Under accelerate level use only the two-cycle bypass program.
// - Protect: elevated reset, write strobe low, A6 low, A1 high, A0 low.
// - Unprotect: same levels as protect but A6 high.
module fbod_host (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_req_valid,
  input wire fbod_pkg::fbod_req_type i_req,
  input wire logic i_word_mode,
  input wire logic i_accel_en,
  input wire logic i_write_protect,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [fbod_pkg::DATA_W-1:0] o_rsp_data,
  output logic o_bypass_active,
  output fbod_pkg::fbod_pins_type o_pins,
  output logic [fbod_pkg::DATA_W-1:0] o_dq_out,
  output logic [fbod_pkg::DATA_W-1:0] o_dq_oe,
  input wire logic [fbod_pkg::DATA_W-1:0] i_dq_in,
  input wire logic i_ready_busy_out
);

  // ************************************************************
  // Sequencer
  // ************************************************************
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ISSUE = 7'b0000010,
    S_WAIT = 7'b0000100,
    S_RST_LOW = 7'b0001000,
    S_RST_HIGH = 7'b0010000,
    S_RESP = 7'b0100000,
    S_PROT = 7'b1000000
  } fbod_st_type;

  fbod_st_type st_ff;
  fbod_st_type nxt_st;
  fbod_pkg::fbod_req_type req_ff;
  logic [2:0] step_ff;
  logic [2:0] nxt_step;
  logic [fbod_pkg::CNT_W-1:0] cnt_ff;
  logic [fbod_pkg::CNT_W-1:0] nxt_cnt;
  logic bypass_ff;
  logic word_ff;
  logic rsp_ff;
  logic [fbod_pkg::DATA_W-1:0] rsp_data_ff;
  logic rb_s1_ff;
  logic rb_s2_ff;
  logic cyc_start;
  logic cyc_done;
  logic [fbod_pkg::DATA_W-1:0] cyc_rdata;
  fbod_pkg::fbod_cyc_type cyc;
  logic [2:0] n_steps;
  logic [11:0] c_addr;
  logic [7:0] c_data;
  logic c_raw;
  logic c_read;
  logic cs_n;
  logic og_n;
  logic we_n;
  logic [fbod_pkg::ADDR_W-1:0] cyc_addr;

  wire in_prot = (req_ff.op == fbod_pkg::OP_PROTECT) || (req_ff.op == fbod_pkg::OP_UNPROTECT);
  wire last_step = (step_ff == n_steps - 3'd1);
  wire cnt_zero = (cnt_ff == '0);
  // Busy flash holds off new work
  wire take = (st_ff == S_IDLE) && i_req_valid && rb_s2_ff;

  // Number of bus cycles per operation
  always_comb begin
    n_steps = 3'd1;
    case (req_ff.op)
      fbod_pkg::OP_PROGRAM: n_steps = bypass_ff ? 3'd2 : 3'd4;
      fbod_pkg::OP_BYPASS_PROGRAM: n_steps = 3'd2;
      fbod_pkg::OP_BYPASS_ENTER: n_steps = 3'd3;
      fbod_pkg::OP_AUTOSELECT: n_steps = 3'd3;
      fbod_pkg::OP_CHIP_ERASE: n_steps = 3'd6;
      fbod_pkg::OP_SECTOR_ERASE: n_steps = 3'd6;
      default: n_steps = 3'd1;
    endcase
  end

  // Per-step address and data of command sequences
  wire [2:0] us = step_ff;
  wire bp = (req_ff.op == fbod_pkg::OP_BYPASS_PROGRAM) ||
    (req_ff.op == fbod_pkg::OP_PROGRAM && bypass_ff);
  always_comb begin
    c_raw = 1'b0;
    c_read = 1'b0;
    c_addr = fbod_pkg::UNLOCK_ADDR1;
    c_data = fbod_pkg::UNLOCK_DATA1;
    if (bp) begin
      c_data = fbod_pkg::CMD_PROGRAM;
      c_raw = (us == 3'd1);
    end else begin
      if (us == 3'd1 || us == 3'd4) begin
        c_addr = fbod_pkg::UNLOCK_ADDR2;
        c_data = fbod_pkg::UNLOCK_DATA2;
      end else if (us == 3'd2) begin
        case (req_ff.op)
          fbod_pkg::OP_PROGRAM: c_data = fbod_pkg::CMD_PROGRAM;
          fbod_pkg::OP_BYPASS_ENTER: c_data = fbod_pkg::CMD_BYPASS;
          fbod_pkg::OP_AUTOSELECT: c_data = fbod_pkg::CMD_AUTOSEL;
          default: c_data = fbod_pkg::CMD_ERASE;
        endcase
      end else if (us == 3'd5) begin
        c_data = (req_ff.op == fbod_pkg::OP_CHIP_ERASE) ?
          fbod_pkg::CMD_CHIP_ERASE : fbod_pkg::CMD_SECT_ERASE;
        c_raw = (req_ff.op == fbod_pkg::OP_SECTOR_ERASE);
      end
      if (req_ff.op == fbod_pkg::OP_PROGRAM && us == 3'd3) begin
        c_raw = 1'b1;
      end
      if (req_ff.op == fbod_pkg::OP_READ_RESET) begin
        c_data = fbod_pkg::CMD_RESET;
        c_raw = 1'b1;
      end
      if (req_ff.op == fbod_pkg::OP_READ || req_ff.op == fbod_pkg::OP_WRITE) begin
        c_raw = 1'b1;
        c_read = (req_ff.op == fbod_pkg::OP_READ);
      end
    end
  end

  // Bank select lives in the upper address bits of the request
  assign cyc_addr = {req_ff.addr[fbod_pkg::ADDR_W-1:12], c_addr};
  assign cyc.is_write = !c_read;
  assign cyc.addr = c_raw ? req_ff.addr : cyc_addr;
  assign cyc.addr_low = c_raw ? req_ff.addr_low : 1'b0;
  assign cyc.data = (c_raw && req_ff.op != fbod_pkg::OP_READ_RESET &&
    !(req_ff.op == fbod_pkg::OP_SECTOR_ERASE)) ? req_ff.data : {8'h00, c_data};
  assign cyc_start = (st_ff == S_ISSUE);

  always_comb begin
    nxt_st = st_ff;
    nxt_step = step_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      S_IDLE: begin
        nxt_step = 3'd0;
        if (take) begin
          if (i_req.op == fbod_pkg::OP_HW_RESET) begin
            nxt_st = S_RST_LOW;
            nxt_cnt = fbod_pkg::CNT_W'(fbod_pkg::RSTP_CYC - 1);
          end else if (i_req.op == fbod_pkg::OP_PROTECT || i_req.op == fbod_pkg::OP_UNPROTECT) begin
            nxt_st = S_PROT;
            nxt_cnt = fbod_pkg::CNT_W'(fbod_pkg::RSTP_CYC - 1);
          end else begin
            nxt_st = S_ISSUE;
          end
        end
      end
      S_ISSUE: nxt_st = S_WAIT;
      S_WAIT: begin
        if (cyc_done) begin
          if (last_step) begin
            nxt_st = S_RESP;
          end else begin
            nxt_step = step_ff + 3'd1;
            nxt_st = S_ISSUE;
          end
        end
      end
      S_PROT: begin
        if (cnt_zero) begin
          nxt_st = S_ISSUE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      S_RST_LOW: begin
        if (cnt_zero) begin
          nxt_st = S_RST_HIGH;
          nxt_cnt = fbod_pkg::CNT_W'(fbod_pkg::RSTH_CYC - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      S_RST_HIGH: begin
        if (cnt_zero) begin
          nxt_st = S_RESP;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      S_RESP: nxt_st = S_IDLE;
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_ff <= S_IDLE;
      req_ff <= '0;
      step_ff <= 3'd0;
      cnt_ff <= '0;
      bypass_ff <= 1'b0;
      word_ff <= 1'b1;
      rsp_ff <= 1'b0;
      rsp_data_ff <= '0;
      rb_s1_ff <= 1'b1;
      rb_s2_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      step_ff <= nxt_step;
      cnt_ff <= nxt_cnt;
      rb_s1_ff <= i_ready_busy_out;
      rb_s2_ff <= rb_s1_ff;
      rsp_ff <= (nxt_st == S_RESP);
      if (take) begin
        req_ff <= i_req;
        word_ff <= i_word_mode;
      end
      if (st_ff == S_WAIT && cyc_done && c_read) begin
        rsp_data_ff <= cyc_rdata;
      end
      // Bypass tracking mirrors the flash's own mode
      if (st_ff == S_RST_LOW || (take && i_req.op == fbod_pkg::OP_READ_RESET)) begin
        bypass_ff <= 1'b0;
      end else if (nxt_st == S_RESP && req_ff.op == fbod_pkg::OP_BYPASS_ENTER) begin
        bypass_ff <= 1'b1;
      end
    end
  end

  fbod_cycle u_cycle (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_start(cyc_start),
    .i_cyc(cyc),
    .i_word(word_ff),
    .i_dq_in(i_dq_in),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_chip_sel_n(cs_n),
    .o_out_gate_n(og_n),
    .o_write_n(we_n),
    .o_addr(),
    .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe)
  );

  // Protect/unprotect force A6/A1/A0 onto the sector address
  wire [fbod_pkg::ADDR_W-1:0] prot_addr = {req_ff.addr[fbod_pkg::ADDR_W-1:7],
    (req_ff.op == fbod_pkg::OP_UNPROTECT), req_ff.addr[5:2], 1'b1, 1'b0};
  assign o_pins.chip_sel_n = cs_n;
  assign o_pins.out_gate_n = og_n;
  assign o_pins.write_n = we_n;
  assign o_pins.reset_n = !(st_ff == S_RST_LOW);
  assign o_pins.reset_elevated = in_prot && (st_ff != S_IDLE) && (st_ff != S_RESP);
  assign o_pins.width_word = word_ff;
  // Accelerate level only while a two-cycle bypass program is running
  assign o_pins.accel_high = i_accel_en && (st_ff != S_IDLE) &&
    (req_ff.op == fbod_pkg::OP_BYPASS_PROGRAM);
  assign o_pins.protect_low_n = !i_write_protect;
  assign o_pins.addr = in_prot ? prot_addr : cyc.addr;
  assign o_req_ready = (st_ff == S_IDLE) && rb_s2_ff;
  assign o_rsp_valid = rsp_ff;
  assign o_rsp_data = rsp_data_ff;
  assign o_bypass_active = bypass_ff || o_pins.accel_high;

endmodule : fbod_host
`default_nettype wire

// ### hw/fbod_pkg.sv
package fbod_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  // ************************************************************
  // Timing counts at 250 MHz (4 ns period)
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_ACCESS_NS = 70;
  localparam int T_WRITE_PULSE_NS = 35;
  localparam int T_SETUP_NS = 8;
  localparam int T_RESET_PULSE_NS = 500;
  localparam int T_RESET_HIGH_NS = 50;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPULSE_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSTP_CYC = (T_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSTH_CYC = (T_RESET_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // ************************************************************
  // Command codes and unlock addresses
  // ************************************************************
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h2aa;
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;

  // ************************************************************
  // Protect / unprotect address bit positions
  // ************************************************************
  localparam int PROT_A6 = 6;
  localparam int PROT_A1 = 1;
  localparam int PROT_A0 = 0;

  // ************************************************************
  // Host operations
  // ************************************************************
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_WRITE = 4'h1,
    OP_PROGRAM = 4'h2,
    OP_BYPASS_PROGRAM = 4'h3,
    OP_BYPASS_ENTER = 4'h4,
    OP_AUTOSELECT = 4'h5,
    OP_CHIP_ERASE = 4'h6,
    OP_SECTOR_ERASE = 4'h7,
    OP_READ_RESET = 4'h8,
    OP_HW_RESET = 4'h9,
    OP_PROTECT = 4'ha,
    OP_UNPROTECT = 4'hb
  } fbod_op_type;

  typedef struct packed {
    fbod_op_type op;
    logic [ADDR_W-1:0] addr;
    logic addr_low;
    logic [DATA_W-1:0] data;
  } fbod_req_type;

  // Pins driven toward the flash; the _n fields are active low
  typedef struct packed {
    logic chip_sel_n;
    logic out_gate_n;
    logic write_n;
    logic reset_n;
    logic reset_elevated;
    logic width_word;
    logic accel_high;
    logic protect_low_n;
    logic [ADDR_W-1:0] addr;
  } fbod_pins_type;

  // One bus cycle on the pins
  typedef struct packed {
    logic is_write;
    logic [ADDR_W-1:0] addr;
    logic addr_low;
    logic [DATA_W-1:0] data;
  } fbod_cyc_type;

endpackage : fbod_pkg

// ### hw/fbod_cycle.sv
`timescale 1ns/100ps
`default_nettype none
// Executes one read or write cycle on the flash strobes
module fbod_cycle (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire fbod_pkg::fbod_cyc_type i_cyc,
  input wire logic i_word,
  input wire logic [fbod_pkg::DATA_W-1:0] i_dq_in,
  output logic o_done,
  output logic [fbod_pkg::DATA_W-1:0] o_rdata,
  output logic o_chip_sel_n,
  output logic o_out_gate_n,
  output logic o_write_n,
  output logic [fbod_pkg::ADDR_W-1:0] o_addr,
  output logic [fbod_pkg::DATA_W-1:0] o_dq_out,
  output logic [fbod_pkg::DATA_W-1:0] o_dq_oe
);

  // ************************************************************
  // Cycle sequencer
  // ************************************************************
  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_SETUP = 4'b0010,
    C_STROBE = 4'b0100,
    C_HOLD = 4'b1000
  } fbod_cst_type;

  fbod_cst_type st_ff;
  fbod_cst_type nxt_st;
  logic [fbod_pkg::CNT_W-1:0] cnt_ff;
  logic [fbod_pkg::CNT_W-1:0] nxt_cnt;
  fbod_pkg::fbod_cyc_type cyc_ff;
  logic [fbod_pkg::DATA_W-1:0] dq_s1_ff;
  logic [fbod_pkg::DATA_W-1:0] dq_s2_ff;
  logic [fbod_pkg::DATA_W-1:0] rdata_ff;
  logic done_ff;
  wire cnt_zero = (cnt_ff == '0);
  wire strobe_len_end = cnt_zero;
  wire [fbod_pkg::CNT_W-1:0] strobe_cnt = cyc_ff.is_write ?
    fbod_pkg::CNT_W'(fbod_pkg::WPULSE_CYC - 1) : fbod_pkg::CNT_W'(fbod_pkg::ACCESS_CYC + 1);
  wire active = (st_ff != C_IDLE);
  wire drive_dq = active && cyc_ff.is_write;
  wire [fbod_pkg::DATA_W-1:0] rd_mask = i_word ? 16'hffff : 16'h00ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      C_IDLE: begin
        if (i_start) begin
          nxt_st = C_SETUP;
          nxt_cnt = fbod_pkg::CNT_W'(fbod_pkg::SETUP_CYC - 1);
        end
      end
      C_SETUP: begin
        if (cnt_zero) begin
          nxt_st = C_STROBE;
          nxt_cnt = strobe_cnt;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      C_STROBE: begin
        if (strobe_len_end) begin
          nxt_st = C_HOLD;
          nxt_cnt = fbod_pkg::CNT_W'(fbod_pkg::SETUP_CYC - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      C_HOLD: begin
        if (cnt_zero) begin
          nxt_st = C_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: nxt_st = C_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_ff <= C_IDLE;
      cnt_ff <= '0;
      cyc_ff <= '0;
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
      rdata_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      dq_s1_ff <= i_dq_in;
      dq_s2_ff <= dq_s1_ff;
      done_ff <= (st_ff == C_HOLD) && cnt_zero;
      if (st_ff == C_IDLE && i_start) begin
        cyc_ff <= i_cyc;
      end
      if (st_ff == C_STROBE && strobe_len_end && !cyc_ff.is_write) begin
        rdata_ff <= dq_s2_ff & rd_mask;
      end
    end
  end

  // Read: select and gate low, write high; write: select and write low, gate high
  assign o_chip_sel_n = !(st_ff == C_SETUP || st_ff == C_STROBE);
  assign o_out_gate_n = !(st_ff == C_STROBE && !cyc_ff.is_write);
  assign o_write_n = !(st_ff == C_STROBE && cyc_ff.is_write);
  assign o_addr = cyc_ff.addr;
  // In byte mode the top data pin carries the low address bit
  assign o_dq_out = i_word ? cyc_ff.data :
    {cyc_ff.addr_low, 7'h00, cyc_ff.data[7:0]};
  assign o_dq_oe = i_word ? {fbod_pkg::DATA_W{drive_dq}} :
    {active, 7'h00, {8{drive_dq}}};
  assign o_done = done_ff;
  assign o_rdata = rdata_ff;

endmodule : fbod_cycle
`default_nettype wire

// ### tb/fbod_host_props.sv
`timescale 1ns/100ps
`default_nettype none
module fbod_host_props (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_req_valid,
  input wire fbod_pkg::fbod_req_type i_req,
  input wire logic i_word_mode,
  input wire logic i_accel_en,
  input wire logic i_write_protect,
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire logic [fbod_pkg::DATA_W-1:0] o_rsp_data,
  input wire logic o_bypass_active,
  input wire fbod_pkg::fbod_pins_type o_pins,
  input wire logic [fbod_pkg::DATA_W-1:0] o_dq_out,
  input wire logic [fbod_pkg::DATA_W-1:0] o_dq_oe,
  input wire logic [fbod_pkg::DATA_W-1:0] i_dq_in,
  input wire logic i_ready_busy_out
);
  // ********
  // Strobe relations
  // ********
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);
  wire cs_on = ~o_pins.chip_sel_n;
  wire og_on = ~o_pins.out_gate_n;
  wire we_on = ~o_pins.write_n;
  wire byte_m = ~o_pins.width_word;
  a_no_contention: assert property (!(og_on && we_on))
    else $error("read and write strobes together");
  a_read_levels: assert property (og_on |-> cs_on && (o_dq_oe & {byte_m ? 1'b0 : 1'b1, 15'h7fff}) == 16'h0000)
    else $error("read strobes or data drive wrong");
  a_write_levels: assert property (we_on |-> cs_on && !og_on)
    else $error("write strobes wrong");
  a_byte_pins: assert property (byte_m && (og_on || we_on) |-> o_dq_oe[15] && o_dq_oe[14:8] == 7'h00)
    else $error("byte mode pin drive wrong");
  a_word_drive: assert property (o_pins.width_word && we_on |-> o_dq_oe == 16'hffff)
    else $error("word write not driving all pins");
  a_write_pulse: assert property ($fell(o_pins.write_n) |-> (!o_pins.write_n) [*8])
    else $error("write pulse too short");
  a_accel_bypass: assert property (o_pins.accel_high |-> o_bypass_active &&
    o_pins.out_gate_n && !o_pins.reset_elevated && o_pins.reset_n)
    else $error("accelerate level outside bypass");
  a_protect_addr: assert property (o_pins.reset_elevated && we_on |-> o_pins.addr[1] && !o_pins.addr[0])
    else $error("protect address bits wrong");
  a_reset_quiet: assert property (!o_pins.reset_n |-> !cs_on && !og_on && !we_on && o_dq_oe == 16'h0000)
    else $error("activity during device reset");
  a_wp_follow: assert property ($rose(i_write_protect) |-> ##[0:3] !o_pins.protect_low_n)
    else $error("protect pin not lowered");
  a_rsp_pulse: assert property (o_rsp_valid |=> !o_rsp_valid)
    else $error("response longer than one cycle");
  c_read: cover property (og_on && byte_m);
  c_accel: cover property (o_pins.accel_high && we_on);
  c_protect: cover property (o_pins.reset_elevated && we_on);
  c_hw_reset: cover property (!o_pins.reset_n);
endmodule : fbod_host_props
bind fbod_host fbod_host_props i_fbod_host_props (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_req_valid(i_req_valid), .i_req(i_req), .i_word_mode(i_word_mode),
  .i_accel_en(i_accel_en), .i_write_protect(i_write_protect), .o_req_ready(o_req_ready),
  .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_bypass_active(o_bypass_active),
  .o_pins(o_pins), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in),
  .i_ready_busy_out(i_ready_busy_out));
`default_nettype wire

// ### tb/fbod_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fbod_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h3c // Arbitrary value
) (
  input wire fbod_pkg::fbod_pins_type i_pins,
  input wire logic [15:0] i_dq_out,
  input wire logic [15:0] i_dq_oe,
  output logic [15:0] o_dq_in,
  output logic o_ready_busy_out
);
  logic [15:0] mem [int];
  logic [511:0] prot = '0;
  logic [2:0] stage = 3'd0;
  logic autosel = 1'b0;
  logic bypass = 1'b0;
  logic armed = 1'b0;
  logic [20:0] wa;
  logic [15:0] wd;
  logic [15:0] rd;
  logic [15:0] last = 16'h0000;
  logic [15:0] drv;
  wire in_rst = !i_pins.reset_n && !i_pins.reset_elevated;
  wire rd_cyc = !in_rst && !i_pins.chip_sel_n && !i_pins.out_gate_n && i_pins.write_n;
  function automatic logic [15:0] rdm(input logic [20:0] x);
    return mem.exists(x) ? mem[x] : 16'hffff;
  endfunction : rdm
  // ********
  // Read path; released pins show the inverse of the last data
  // ********
  always @* begin
    rd = rdm(i_pins.addr);
    if (autosel) rd = {8'h00, ID_CODE};
    else if (!i_pins.width_word) rd = {8'h00, i_dq_out[15] ? rd[15:8] : rd[7:0]};
  end
  assign drv = rd_cyc ? {{8{i_pins.width_word}}, 8'hff} : 16'h0000;
  assign o_dq_in = (i_dq_oe & i_dq_out) | (~i_dq_oe & ((drv & rd) | (~drv & ~last)));
  assign o_ready_busy_out = 1'b1; // Embedded work completes at once
  always @(posedge i_pins.out_gate_n) last = rd;
  // ********
  // Command latch
  // ********
  always @(i_pins or i_dq_out) begin
    if (!in_rst && !i_pins.chip_sel_n && !i_pins.write_n && i_pins.out_gate_n) begin
      wa = i_pins.addr;
      wd = i_dq_out;
      armed = 1'b1;
    end
  end
  task automatic cmd(input logic [20:0] ad, input logic [15:0] d);
    logic [15:0] old;
    logic lock;
    logic ul1;
    logic ul2;
    int q[$];
    old = rdm(ad);
    lock = !i_pins.accel_high && (prot[ad[20:12]] || (!i_pins.protect_low_n && &ad[20:13]));
    ul1 = ad[11:0] == fbod_pkg::UNLOCK_ADDR1 && d[7:0] == fbod_pkg::UNLOCK_DATA1;
    ul2 = ad[11:0] == fbod_pkg::UNLOCK_ADDR2 && d[7:0] == fbod_pkg::UNLOCK_DATA2;
    if (stage != 3'd5 && d[7:0] == fbod_pkg::CMD_RESET) begin
      stage = 3'd0;
      autosel = 1'b0;
      bypass = 1'b0;
    end else case (stage)
      3'd0: begin
        if ((bypass || i_pins.accel_high) && d[7:0] == fbod_pkg::CMD_PROGRAM) stage = 3'd5;
        else if (ul1) stage = 3'd1;
      end
      3'd1: stage = ul2 ? 3'd2 : 3'd0;
      3'd2: begin
        stage = d[7:0] == fbod_pkg::CMD_PROGRAM ? 3'd5 : d[7:0] == fbod_pkg::CMD_ERASE ? 3'd3 : 3'd0;
        if (d[7:0] == fbod_pkg::CMD_AUTOSEL) autosel = 1'b1;
        if (d[7:0] == fbod_pkg::CMD_BYPASS) bypass = 1'b1;
      end
      3'd3: stage = ul1 ? 3'd4 : 3'd0;
      3'd4: stage = ul2 ? 3'd6 : 3'd0;
      3'd5: begin
        if (!lock) mem[ad] = i_pins.width_word ? old & d : d[15] ?
          {old[15:8] & d[7:0], old[7:0]} : {old[15:8], old[7:0] & d[7:0]};
        stage = 3'd0;
      end
      default: begin
        foreach (mem[k]) if (d[7:0] == fbod_pkg::CMD_CHIP_ERASE || k[20:12] == ad[20:12]) q.push_back(k);
        foreach (q[j]) mem.delete(q[j]);
        stage = 3'd0;
      end
    endcase
  endtask : cmd
  always @(posedge i_pins.write_n or negedge i_pins.reset_n) begin
    if (in_rst) begin
      stage = 3'd0;
      autosel = 1'b0;
      bypass = 1'b0;
      armed = 1'b0;
    end else if (armed) begin
      armed = 1'b0;
      if (i_pins.reset_elevated) prot[wa[20:12]] = !wa[6];
      else cmd(wa, wd);
    end
  end
endmodule : fbod_flash_model
`default_nettype wire

// ### tb/test_fbod_host.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_fbod_host;
  // ********
  // Hookup
  // ********
  localparam logic [7:0] ID = 8'h5b; // Arbitrary value
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_req_valid = 1'b0;
  logic i_word_mode = 1'b1;
  logic i_accel_en = 1'b0;
  logic i_write_protect = 1'b0;
  fbod_pkg::fbod_req_type i_req = '0;
  logic o_req_ready, o_rsp_valid, o_bypass_active, rdy_busy;
  logic [15:0] o_rsp_data, o_dq_out, o_dq_oe, dq_in, got;
  fbod_pkg::fbod_pins_type o_pins;
  int n_fail = 0, n_checks = 0, n_wr = 0, n_cyc = 0;
  initial forever #2 i_mclk = ~i_mclk;
  fbod_host i_fbod_host (.i_mclk(i_mclk), .i_srst(i_srst), .i_req_valid(i_req_valid),
    .i_req(i_req), .i_word_mode(i_word_mode), .i_accel_en(i_accel_en),
    .i_write_protect(i_write_protect), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_rsp_data(o_rsp_data), .o_bypass_active(o_bypass_active), .o_pins(o_pins),
    .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(dq_in), .i_ready_busy_out(rdy_busy));
  fbod_flash_model #(.ID_CODE(ID)) i_fbod_flash_model (.i_pins(o_pins), .i_dq_out(o_dq_out),
    .i_dq_oe(o_dq_oe), .o_dq_in(dq_in), .o_ready_busy_out(rdy_busy));
  always @(negedge o_pins.write_n) n_wr++;
  always @(posedge i_mclk) begin
    n_cyc++;
    if (n_cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ********
  // Shared tasks
  // ********
  task automatic op(input fbod_pkg::fbod_op_type o, input logic [20:0] a, input logic lo,
      input logic [15:0] d);
    int k;
    @(posedge i_mclk);
    i_req <= '{o, a, lo, d};
    i_req_valid <= 1'b1;
    k = 0;
    do @(posedge i_mclk); while (o_req_ready !== 1'b1 && ++k < 100);
    i_req_valid <= 1'b0;
    k = 0;
    do @(posedge i_mclk); while (o_rsp_valid !== 1'b1 && ++k < 2000);
    if (k >= 2000) `CHK("response", 1'b1, 1'b0)
    got = o_rsp_data;
  endtask : op
  task automatic rd_chk(input string nm, input logic [20:0] a, input logic lo,
      input logic [15:0] e);
    op(fbod_pkg::OP_READ, a, lo, 16'h0000);
    `CHK(nm, e, got)
  endtask : rd_chk
  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    `CHK("idle_cs", 1'b1, o_pins.chip_sel_n)
    rd_chk("boot_read", 21'h000100, 1'b0, 16'hffff);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_prog;
    n_wr = 0;
    op(fbod_pkg::OP_PROGRAM, 21'h012345, 1'b0, 16'h1234);
    `CHK("prog_writes", 4, n_wr)
    rd_chk("word_read", 21'h012345, 1'b0, 16'h1234);
    i_word_mode <= 1'b0;
    rd_chk("byte_hi", 21'h012345, 1'b1, 16'h0012);
    rd_chk("byte_lo", 21'h012345, 1'b0, 16'h0034);
    op(fbod_pkg::OP_PROGRAM, 21'h0abcd0, 1'b1, 16'h00a5);
    rd_chk("byte_prog", 21'h0abcd0, 1'b1, 16'h00a5);
    i_word_mode <= 1'b1;
    rd_chk("byte_prog_w", 21'h0abcd0, 1'b0, 16'ha5ff);
    $display("t_prog done");
  endtask : t_prog
  task automatic t_bypass;
    op(fbod_pkg::OP_BYPASS_ENTER, 21'h000000, 1'b0, 16'h0000);
    `CHK("byp_on", 1'b1, o_bypass_active)
    n_wr = 0;
    op(fbod_pkg::OP_PROGRAM, 21'h0abcd1, 1'b0, 16'h5a5a);
    `CHK("byp_writes", 2, n_wr)
    op(fbod_pkg::OP_READ_RESET, 21'h000000, 1'b0, 16'h0000);
    `CHK("byp_off", 1'b0, o_bypass_active)
    rd_chk("byp_data", 21'h0abcd1, 1'b0, 16'h5a5a);
    $display("t_bypass done");
  endtask : t_bypass
  task automatic t_protect;
    op(fbod_pkg::OP_PROTECT, 21'h100040, 1'b0, 16'h0000);
    op(fbod_pkg::OP_PROGRAM, 21'h100040, 1'b0, 16'h0f0f);
    rd_chk("prot_hold", 21'h100040, 1'b0, 16'hffff);
    i_accel_en <= 1'b1;
    n_wr = 0;
    op(fbod_pkg::OP_BYPASS_PROGRAM, 21'h100041, 1'b0, 16'h3c3c);
    `CHK("acc_writes", 2, n_wr)
    i_accel_en <= 1'b0;
    rd_chk("acc_data", 21'h100041, 1'b0, 16'h3c3c);
    op(fbod_pkg::OP_UNPROTECT, 21'h100040, 1'b0, 16'h0000);
    op(fbod_pkg::OP_PROGRAM, 21'h100040, 1'b0, 16'h0f0f);
    rd_chk("unprot", 21'h100040, 1'b0, 16'h0f0f);
    i_write_protect <= 1'b1;
    op(fbod_pkg::OP_PROGRAM, 21'h1ff010, 1'b0, 16'h1111);
    rd_chk("wp_boot", 21'h1ff010, 1'b0, 16'hffff);
    i_write_protect <= 1'b0;
    $display("t_protect done");
  endtask : t_protect
  task automatic t_auto;
    n_wr = 0;
    op(fbod_pkg::OP_AUTOSELECT, 21'h000000, 1'b0, 16'h0000);
    `CHK("auto_writes", 3, n_wr)
    rd_chk("id_code", 21'h012345, 1'b0, {8'h00, ID});
    op(fbod_pkg::OP_WRITE, 21'h000000, 1'b0, 16'h00f0);
    rd_chk("raw_exit", 21'h012345, 1'b0, 16'h1234);
    op(fbod_pkg::OP_AUTOSELECT, 21'h000000, 1'b0, 16'h0000);
    op(fbod_pkg::OP_HW_RESET, 21'h000000, 1'b0, 16'h0000);
    rd_chk("after_rst", 21'h012345, 1'b0, 16'h1234);
    $display("t_auto done");
  endtask : t_auto
  task automatic t_erase;
    op(fbod_pkg::OP_SECTOR_ERASE, 21'h012000, 1'b0, 16'h0000);
    rd_chk("sect_gone", 21'h012345, 1'b0, 16'hffff);
    rd_chk("sect_keep", 21'h0abcd1, 1'b0, 16'h5a5a);
    op(fbod_pkg::OP_CHIP_ERASE, 21'h000000, 1'b0, 16'h0000);
    rd_chk("chip_gone", 21'h0abcd1, 1'b0, 16'hffff);
    $display("t_erase done");
  endtask : t_erase
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(posedge i_mclk);
    i_srst <= 1'b0;
    t_reset();
    t_prog();
    t_bypass();
    t_protect();
    t_auto();
    t_erase();
    tally_and_finish();
  end
endmodule : test_fbod_host
`default_nettype wire
